// ==== core/alu_consts.svh ====
/*
 Named constants of the byte arithmetic and logic unit: status bit
 positions, address map of the software port and fixed byte values.
 Assumes it is included once per file by its bare name.
*/
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// Status byte bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5

// Software port map
`define RF_TOP_ADDR 6'h1f
`define STATUS_ADDR 6'h20

// Fixed byte values
`define STATUS_RST 8'h00
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hff

`endif

// ==== core/alu_pkg.sv ====
/*
 Types and shared decode helpers of the byte arithmetic and logic unit.
 Assumes the instruction decoder drives operation codes of type op_t.
*/
package alu_pkg;

    // Operation codes presented by the decoder
    typedef enum logic [4:0] {
        op_nop,
        op_sum_two_regs,
        op_sum_with_carry,
        op_word_immediate_plus,
        op_difference_regs,
        op_difference_immediate,
        op_borrow_difference_regs,
        op_borrow_difference_immediate,
        op_word_immediate_minus,
        op_conjunction_regs,
        op_conjunction_immediate,
        op_disjunction_regs,
        op_disjunction_immediate,
        op_exclusive_disjunction,
        op_bitwise_invert,
        op_arithmetic_inverse,
        op_bits_set_mask,
        op_bits_clear_mask
    } op_t;

    // Word sequencer states
    typedef enum logic {
        seq_idle,
        seq_word_hi
    } seq_t;

    // Second operand comes from the immediate field
    function automatic logic uses_imm(input op_t op);
        uses_imm = (op == op_difference_immediate) || (op == op_borrow_difference_immediate)
            || (op == op_word_immediate_plus) || (op == op_word_immediate_minus)
            || (op == op_conjunction_immediate) || (op == op_disjunction_immediate)
            || (op == op_bits_set_mask) || (op == op_bits_clear_mask);
    endfunction

    // Adder runs as a subtractor
    function automatic logic is_sub(input op_t op);
        is_sub = (op == op_difference_regs) || (op == op_difference_immediate)
            || (op == op_borrow_difference_regs) || (op == op_borrow_difference_immediate)
            || (op == op_word_immediate_minus) || (op == op_arithmetic_inverse);
    endfunction

endpackage

// ==== core/alu_adder8.sv ====
/*
 Eight-bit adder/subtractor with carry, half-carry and overflow.
 Assumes cin is a carry for addition and a borrow for subtraction.
*/
`timescale 1ns/1ns
module alu_adder8 (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [7:0] sum,
    output logic cout,
    output logic half,
    output logic ovf
);
    logic [7:0] b_eff;
    logic c_eff;
    logic [8:0] full;
    logic [4:0] nib;

    // Subtraction as a plus inverted b plus inverted borrow
    assign b_eff = sub ? ~b : b;
    assign c_eff = sub ? ~cin : cin;
    assign full = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_eff};
    assign nib = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
    assign sum = full[7:0];
    // Borrow is the inverse of the carry out
    assign cout = full[8] ^ sub;
    assign half = nib[4] ^ sub;
    // Same-signed inputs giving a differently signed result
    assign ovf = (a[7] == b_eff[7]) && (full[7] != a[7]);
endmodule

// ==== core/alu_logic8.sv ====
/*
 Eight-bit bitwise unit for the conjunction, disjunction, exclusive,
 invert and mask operations. Assumes a is the destination byte.
*/
`timescale 1ns/1ns
`include "alu_consts.svh"
module alu_logic8
    import alu_pkg::*;
(
    input wire op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    output logic [7:0] y
);
    // Pure combinational selection
    always_comb
    begin
        unique case (op)
            op_conjunction_regs, op_conjunction_immediate: y = a & b;
            op_disjunction_regs, op_disjunction_immediate, op_bits_set_mask: y = a | b;
            op_exclusive_disjunction: y = a ^ b;
            op_bitwise_invert: y = `BYTE_ONES - a;
            op_bits_clear_mask: y = a & (`BYTE_ONES - b);
            default: y = a;
        endcase
    end
endmodule

// ==== core/byte_arith_logic_unit.sv ====
/*
 Byte arithmetic and logic datapath with its own 32-entry register file
 and status byte, plus a software port to read and write both.
 Assumes the decoder issues one operation per op_valid pulse and holds
 off while busy is high; all inputs are synchronous to mclk.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "alu_consts.svh"
// Overview of operation
// - Add registers, optional carry, flags ZCNVH
// - Word plus immediate, two clocks, ZCNVS
// - Subtract register or immediate, flags ZCNVH
// - Subtract register and carry, flags ZCNVH
// - Subtract immediate and carry, flags ZCNVH
// - Word minus immediate, two clocks, ZCNVS
// - Conjunction, flags Z N V only
// - Inclusive or exclusive disjunction, flags ZNV
// - Invert sets ZCNV; negate also H
// - Set mask bits, flags Z N V
// - Clear mask bits, flags Z N V
module byte_arith_logic_unit
    import alu_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire op_t op,
    input wire logic [4:0] dest_idx,
    input wire logic [4:0] src_idx,
    input wire logic [7:0] imm,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    output logic [7:0] status,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [31:0][7:0] rf;
        logic [7:0] sreg;
        seq_t seq;
        logic [4:0] pair;
        logic carry;
        logic wsub;
        logic [7:0] rdata;
        logic done;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic take;
    logic [4:0] hi_idx;
    logic [7:0] dst_val;
    logic [7:0] opnd_b;
    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_cin;
    logic add_sub;
    logic [7:0] add_sum;
    logic add_cout;
    logic add_half;
    logic add_ovf;
    logic [7:0] log_y;
    logic [15:0] word_at_dest;
    logic [15:0] word_at_pair;

    // Operations are refused while the word sequencer is busy
    assign take = op_valid && (st_q.seq == seq_idle);
    assign hi_idx = 5'(st_q.pair + 5'd1);
    assign dst_val = st_q.rf[dest_idx];
    assign opnd_b = uses_imm(op) ? imm : st_q.rf[src_idx];
    assign word_at_dest = {st_q.rf[5'(dest_idx + 5'd1)], dst_val};
    assign word_at_pair = {st_q.rf[hi_idx], st_q.rf[st_q.pair]};

    // Adder operands; second word cycle adds only the stored carry
    always_comb
    begin
        add_a = dst_val;
        add_b = opnd_b;
        add_cin = 1'b0;
        add_sub = is_sub(op);
        if (st_q.seq == seq_word_hi)
        begin
            add_a = st_q.rf[hi_idx];
            add_b = `BYTE_ZERO;
            add_cin = st_q.carry;
            add_sub = st_q.wsub;
        end
        else if (op == op_arithmetic_inverse)
        begin
            add_a = `BYTE_ZERO;
            add_b = dst_val;
        end
        else if ((op == op_sum_with_carry) || (op == op_borrow_difference_regs)
            || (op == op_borrow_difference_immediate))
        begin
            add_cin = st_q.sreg[`FLAG_C];
        end
    end

    alu_adder8 u_adder (
        .a(add_a),
        .b(add_b),
        .cin(add_cin),
        .sub(add_sub),
        .sum(add_sum),
        .cout(add_cout),
        .half(add_half),
        .ovf(add_ovf)
    );

    alu_logic8 u_logic (
        .op(op),
        .a(dst_val),
        .b(opnd_b),
        .y(log_y)
    );

    // Next state: software port first, datapath writeback wins on overlap
    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.rdata = `BYTE_ZERO;
        if (rd_stb)
        begin
            if (addr <= `RF_TOP_ADDR)
                st_d.rdata = st_q.rf[addr[4:0]];
            else if (addr == `STATUS_ADDR)
                st_d.rdata = st_q.sreg;
        end
        if (wr_stb)
        begin
            if (addr <= `RF_TOP_ADDR)
                st_d.rf[addr[4:0]] = wdata;
            else if (addr == `STATUS_ADDR)
                st_d.sreg = wdata;
        end
        if (st_q.seq == seq_word_hi)
        begin
            // High byte of the pair, flags over all sixteen bits
            st_d.rf[hi_idx] = add_sum;
            st_d.sreg[`FLAG_Z] = (add_sum == `BYTE_ZERO) && (st_q.rf[st_q.pair] == `BYTE_ZERO);
            st_d.sreg[`FLAG_C] = add_cout;
            st_d.sreg[`FLAG_N] = add_sum[7];
            st_d.sreg[`FLAG_V] = add_ovf;
            st_d.sreg[`FLAG_S] = add_sum[7] ^ add_ovf;
            st_d.seq = seq_idle;
            st_d.done = 1'b1;
        end
        else if (take)
        begin
            unique case (op)
                op_sum_two_regs, op_sum_with_carry, op_difference_regs,
                op_difference_immediate, op_borrow_difference_regs,
                op_borrow_difference_immediate, op_arithmetic_inverse:
                begin
                    // Byte arithmetic; S is left alone
                    st_d.rf[dest_idx] = add_sum;
                    st_d.sreg[`FLAG_Z] = (add_sum == `BYTE_ZERO);
                    st_d.sreg[`FLAG_C] = add_cout;
                    st_d.sreg[`FLAG_N] = add_sum[7];
                    st_d.sreg[`FLAG_V] = add_ovf;
                    st_d.sreg[`FLAG_H] = add_half;
                    st_d.done = 1'b1;
                end
                op_word_immediate_plus, op_word_immediate_minus:
                begin
                    // Low byte now; flags wait for the high byte
                    st_d.rf[dest_idx] = add_sum;
                    st_d.carry = add_cout;
                    st_d.wsub = is_sub(op);
                    st_d.pair = dest_idx;
                    st_d.seq = seq_word_hi;
                end
                op_conjunction_regs, op_conjunction_immediate, op_disjunction_regs,
                op_disjunction_immediate, op_exclusive_disjunction,
                op_bits_set_mask, op_bits_clear_mask, op_bitwise_invert:
                begin
                    // Bitwise family touches Z N V only, invert also sets C
                    st_d.rf[dest_idx] = log_y;
                    st_d.sreg[`FLAG_Z] = (log_y == `BYTE_ZERO);
                    st_d.sreg[`FLAG_N] = log_y[7];
                    st_d.sreg[`FLAG_V] = 1'b0;
                    if (op == op_bitwise_invert)
                        st_d.sreg[`FLAG_C] = 1'b1;
                    st_d.done = 1'b1;
                end
                default:
                begin
                    // No-operation and unused codes change nothing
                    st_d.done = 1'b0;
                end
            endcase
        end
    end

    // Whole state in one register
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.sreg <= `STATUS_RST;
            st_q.seq <= seq_idle;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rdata;
    assign status = st_q.sreg;
    assign busy = (st_q.seq == seq_word_hi);
    assign done = st_q.done;

    // Checks of the datapath against its inputs
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_take(op_t o);
        take && !wr_stb && (op == o);
    endsequence

    sequence s_word_two;
        busy ##1 (!busy && done);
    endsequence

    a_add_result: assert property (s_take(op_sum_two_regs) |=>
        st_q.rf[$past(dest_idx)] == 8'($past(dst_val) + $past(opnd_b)))
        else $error("add result wrong");

    a_word_plus: assert property (s_take(op_word_immediate_plus) |=> s_word_two ##0
        (word_at_pair == 16'($past(word_at_dest, 2) + {8'h00, $past(imm, 2)})))
        else $error("word add wrong");

    a_sub_imm_carry: assert property (s_take(op_difference_immediate) |=>
        (st_q.sreg[`FLAG_C] == ($past(dst_val) < $past(imm))))
        else $error("subtract borrow wrong");

    a_sbc_result: assert property (s_take(op_borrow_difference_regs) |=>
        st_q.rf[$past(dest_idx)] == 8'($past(dst_val) - $past(opnd_b)
            - {7'h00, $past(st_q.sreg[`FLAG_C])}))
        else $error("borrow subtract wrong");

    a_borrow_difference_immediate_flags: assert property (s_take(op_borrow_difference_immediate) |=>
        (st_q.sreg[`FLAG_Z] == (st_q.rf[$past(dest_idx)] == `BYTE_ZERO))
        && $stable(st_q.sreg[`FLAG_S]))
        else $error("borrow immediate flags wrong");

    a_word_sign: assert property (s_take(op_word_immediate_minus) |=> s_word_two ##0
        (status[`FLAG_S] == (status[`FLAG_N] ^ status[`FLAG_V]))
        && (word_at_pair == 16'($past(word_at_dest, 2) - {8'h00, $past(imm, 2)})))
        else $error("word subtract wrong");

    a_and_keeps: assert property (s_take(op_conjunction_immediate) |=>
        !status[`FLAG_V] && $stable(status[`FLAG_C]) && $stable(status[`FLAG_H]))
        else $error("conjunction flags wrong");

    a_xor_result: assert property (s_take(op_exclusive_disjunction) |=>
        st_q.rf[$past(dest_idx)] == ($past(dst_val) ^ $past(opnd_b)))
        else $error("exclusive result wrong");

    a_invert_carry: assert property (s_take(op_bitwise_invert) |=>
        status[`FLAG_C] && (st_q.rf[$past(dest_idx)] == ~$past(dst_val)))
        else $error("invert wrong");

    a_set_mask: assert property (s_take(op_bits_set_mask) |=>
        st_q.rf[$past(dest_idx)] == ($past(dst_val) | $past(imm)))
        else $error("set mask wrong");

    a_clear_mask: assert property (s_take(op_bits_clear_mask) |=>
        st_q.rf[$past(dest_idx)] == ($past(dst_val) & ~$past(imm)))
        else $error("clear mask wrong");

    a_word_keeps_h: assert property (s_take(op_word_immediate_plus) |=>
        $stable(status) ##1 (status[`FLAG_H] == $past(status[`FLAG_H], 2)))
        else $error("word op touched half carry");

    // Carry must chain into the byte sum and come back out on C
    a_carry_sum: assert property (s_take(op_sum_with_carry) |=>
        {status[`FLAG_C], st_q.rf[$past(dest_idx)]} == 9'({1'b0, $past(dst_val)}
            + {1'b0, $past(opnd_b)} + {8'h00, $past(status[`FLAG_C])}))
        else $error("carry add wrong");

    a_sub_regs: assert property (s_take(op_difference_regs) |=>
        (st_q.rf[$past(dest_idx)] == 8'($past(dst_val) - $past(opnd_b)))
        && $stable(status[`FLAG_S]))
        else $error("register subtract wrong");

    // Negate borrows unless the operand was zero
    a_neg_carry: assert property (s_take(op_arithmetic_inverse) |=>
        (status[`FLAG_C] == (st_q.rf[$past(dest_idx)] != `BYTE_ZERO))
        && (st_q.rf[$past(dest_idx)] == 8'(`BYTE_ZERO - $past(dst_val))))
        else $error("negate wrong");

    a_or_result: assert property (s_take(op_disjunction_immediate) |=>
        (st_q.rf[$past(dest_idx)] == ($past(dst_val) | $past(imm)))
        && $stable(status[`FLAG_H]))
        else $error("disjunction wrong");

    // Low byte cycle of a word op leaves every flag for the high cycle
    a_word_low: assert property (s_take(op_word_immediate_minus) |=>
        busy && $stable(status))
        else $error("word low cycle wrong");

    a_nop_quiet: assert property (s_take(op_nop) |=>
        !done && $stable(status))
        else $error("no-operation changed state");

    // Word sequencer never stalls past its second clock
    a_busy_ends: assert property (busy |=>
        !busy && done)
        else $error("word op overran two clocks");
endmodule

// ==== tb/op_issuer.sv ====
/*
 Decoder stand-in: turns one-cycle bench requests into operation pulses.
 Assumes requests arrive only while the datapath is idle.
*/
`timescale 1ns/1ns
module op_issuer
    import alu_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic req,
    input wire op_t req_op,
    input wire logic [4:0] req_dst,
    input wire logic [4:0] req_src,
    input wire logic [7:0] req_imm,
    input wire logic busy,
    output logic op_valid,
    output op_t op,
    output logic [4:0] dest_idx,
    output logic [4:0] src_idx,
    output logic [7:0] imm
);
    // Index and immediate fields scramble between pulses while op holds, so stale operands never look valid
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            op_valid <= 1'b0;
            op <= op_nop;
            dest_idx <= 5'h00;
            src_idx <= 5'h00;
            imm <= 8'h00;
        end
        else
        begin
            op_valid <= req && !busy;
            if (req && !busy)
            begin
                op <= req_op;
                dest_idx <= req_dst;
                src_idx <= req_src;
                imm <= req_imm;
            end
            else
            begin
                dest_idx <= ~dest_idx;
                src_idx <= ~src_idx;
                imm <= ~imm;
            end
        end
    end
endmodule

// ==== tb/byte_arith_logic_unit_bench.sv ====
/*
 Self-checking bench of the byte arithmetic and logic unit.
 Assumes op_issuer feeds the operation port and core/ is on the include path.
*/
`timescale 1ns/1ns
`include "alu_consts.svh"
module byte_arith_logic_unit_bench
    import alu_pkg::*;
;
    logic mclk, sys_rst, req, op_valid, wr_stb, rd_stb, busy, done;
    op_t req_op, op;
    logic [4:0] req_dst, req_src, dest_idx, src_idx;
    logic [7:0] req_imm, imm, wdata, rd_data, status, st;
    logic [7:0] rf [32];
    logic [5:0] addr;
    int errors, checks, quiet;

    op_issuer u_iss (.mclk(mclk), .sys_rst(sys_rst), .req(req), .req_op(req_op),
        .req_dst(req_dst), .req_src(req_src), .req_imm(req_imm), .busy(busy),
        .op_valid(op_valid), .op(op), .dest_idx(dest_idx), .src_idx(src_idx), .imm(imm));
    byte_arith_logic_unit u_dut (.mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op(op), .dest_idx(dest_idx), .src_idx(src_idx), .imm(imm), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .status(status), .busy(busy), .done(done));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Software write; shadow copy follows so expectations track it
    task automatic sw_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        if (a < 6'h20)
            rf[a[4:0]] = d;
        else if (a == `STATUS_ADDR)
            st = d;
    endtask

    // Read data only stands in the cycle after the strobe
    task automatic sw_rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        check("rd_data", {8'h00, rd_data}, {8'h00, exp});
        // Read data must fall back to zero one cycle later
        @(negedge mclk);
        check("rd_idle", {8'h00, rd_data}, 16'h0000);
    endtask

    // Predict result and flags, issue, then compare timing, flags and registers
    task automatic run_op(input op_t o, input logic [4:0] d, s, input logic [7:0] k);
        logic [7:0] a, b, r;
        logic [8:0] w;
        logic [4:0] hw, d1;
        logic [15:0] p;
        logic [16:0] x;
        logic cin, sub, ar, wd, bz;
        int n;
        a = rf[d];
        d1 = d + 5'h01;
        p = {rf[d1], rf[d]};
        {b, cin, sub, ar} = 11'h000;
        r = a;
        wd = (o == op_word_immediate_plus) || (o == op_word_immediate_minus);
        case (o)
            op_sum_two_regs: {b, ar} = {rf[s], 1'b1};
            op_sum_with_carry: {b, cin, ar} = {rf[s], st[`FLAG_C], 1'b1};
            op_difference_regs: {b, sub, ar} = {rf[s], 2'h3};
            op_difference_immediate: {b, sub, ar} = {k, 2'h3};
            op_borrow_difference_regs: {b, cin, sub, ar} = {rf[s], st[`FLAG_C], 2'h3};
            op_borrow_difference_immediate: {b, cin, sub, ar} = {k, st[`FLAG_C], 2'h3};
            op_arithmetic_inverse: {a, b, sub, ar} = {8'h00, a, 2'h3};
            op_conjunction_regs: r = a & rf[s];
            op_conjunction_immediate: r = a & k;
            op_disjunction_regs: r = a | rf[s];
            op_disjunction_immediate, op_bits_set_mask: r = a | k;
            op_exclusive_disjunction: r = a ^ rf[s];
            op_bitwise_invert: r = 8'hff - a;
            op_bits_clear_mask: r = a & (8'hff - k);
            default: ;
        endcase
        if (ar)
        begin
            w = sub ? {1'b0, a} - b - cin : a + b + cin;
            hw = sub ? {1'b0, a[3:0]} - b[3:0] - cin : a[3:0] + b[3:0] + cin;
            r = w[7:0];
            st[`FLAG_C] = w[8];
            st[`FLAG_H] = hw[4];
            st[`FLAG_V] = (r[7] != a[7]) && ((a[7] == b[7]) != sub);
        end
        else if (!wd)
        begin
            st[`FLAG_V] = 1'b0;
            if (o == op_bitwise_invert)
                st[`FLAG_C] = 1'b1;
        end
        if (wd)
        begin
            x = (o == op_word_immediate_minus) ? {1'b0, p} - k : p + k;
            st[`FLAG_C] = x[16];
            st[`FLAG_Z] = (x[15:0] == 16'h0000);
            st[`FLAG_N] = x[15];
            st[`FLAG_V] = (o == op_word_immediate_minus) ? p[15] & !x[15] : !p[15] & x[15];
            st[`FLAG_S] = x[15] ^ st[`FLAG_V];
            {rf[d1], rf[d]} = x[15:0];
        end
        else
        begin
            st[`FLAG_Z] = (r == 8'h00);
            st[`FLAG_N] = r[7];
            rf[d] = r;
        end
        @(posedge mclk);
        req <= 1'b1;
        req_op <= o;
        req_dst <= d;
        req_src <= s;
        req_imm <= k;
        @(posedge mclk);
        req <= 1'b0;
        n = 0;
        bz = 1'b0;
        // First sample falls in the cycle that carries op_valid
        do
        begin
            @(negedge mclk);
            n++;
            if (n == 2)
                bz = busy;
        end while (done !== 1'b1 && n < 8);
        if (done !== 1'b1)
        begin
            errors++;
            wrap_up();
        end
        check("latency", 16'(n - 1), wd ? 16'h0002 : 16'h0001);
        check("busy", {15'h0000, bz}, {15'h0000, wd});
        check("status", {8'h00, status}, {8'h00, st});
        @(negedge mclk);
        check("done_fall", {15'h0000, done}, 16'h0000);
        sw_rd({1'b0, d}, rf[d]);
        if (wd)
            sw_rd({1'b0, d1}, rf[d1]);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Main sequence: reset, then awkward operands for every operation code
    initial
    begin
        sys_rst = 1'b1;
        {req, wr_stb, rd_stb} = 3'h0;
        req_op = op_nop;
        {req_dst, req_src, req_imm, addr, wdata} = 32'h00000000;
        errors = 0;
        checks = 0;
        st = `STATUS_RST;
        for (int i = 0; i < 32; i++)
            rf[i] = 8'h00;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        check("status", {8'h00, status}, 16'h0000);
        sw_wr(6'h01, 8'h0f);
        sw_wr(6'h02, 8'h01);
        run_op(op_sum_two_regs, 5'h01, 5'h02, 8'h00);
        sw_wr(`STATUS_ADDR, 8'hd1);
        sw_wr(6'h03, 8'h7f);
        run_op(op_sum_with_carry, 5'h03, 5'h02, 8'h00);
        sw_wr(6'h18, 8'hff);
        sw_wr(6'h19, 8'hff);
        run_op(op_word_immediate_plus, 5'h18, 5'h00, 8'h01);
        sw_wr(6'h1f, 8'hf0);
        sw_wr(6'h00, 8'h7f);
        run_op(op_word_immediate_plus, 5'h1f, 5'h00, 8'h10);
        sw_wr(6'h06, 8'h01);
        run_op(op_difference_regs, 5'h05, 5'h06, 8'h00);
        run_op(op_difference_immediate, 5'h01, 5'h00, 8'h10);
        sw_wr(6'h07, 8'h80);
        sw_wr(`STATUS_ADDR, 8'h21);
        run_op(op_borrow_difference_regs, 5'h07, 5'h08, 8'h00);
        run_op(op_borrow_difference_immediate, 5'h07, 5'h00, 8'h7f);
        sw_wr(`STATUS_ADDR, 8'h01);
        run_op(op_borrow_difference_immediate, 5'h07, 5'h00, 8'h00);
        sw_wr(6'h1b, 8'h80);
        run_op(op_word_immediate_minus, 5'h1a, 5'h00, 8'h01);
        run_op(op_word_immediate_minus, 5'h1a, 5'h00, 8'hff);
        sw_wr(`STATUS_ADDR, 8'hff);
        run_op(op_conjunction_regs, 5'h07, 5'h05, 8'h00);
        run_op(op_conjunction_immediate, 5'h07, 5'h00, 8'h00);
        run_op(op_disjunction_regs, 5'h07, 5'h1b, 8'h00);
        run_op(op_disjunction_immediate, 5'h07, 5'h00, 8'h0c);
        run_op(op_exclusive_disjunction, 5'h07, 5'h07, 8'h00);
        run_op(op_bitwise_invert, 5'h07, 5'h00, 8'h00);
        sw_wr(6'h0a, 8'h80);
        run_op(op_arithmetic_inverse, 5'h0a, 5'h00, 8'h00);
        run_op(op_arithmetic_inverse, 5'h05, 5'h00, 8'h00);
        run_op(op_arithmetic_inverse, 5'h09, 5'h00, 8'h00);
        run_op(op_bits_set_mask, 5'h09, 5'h00, 8'ha5);
        run_op(op_bits_clear_mask, 5'h09, 5'h00, 8'h81);
        // No-operation leaves flags and registers alone and raises no done
        @(posedge mclk);
        req <= 1'b1;
        req_op <= op_nop;
        req_dst <= 5'h09;
        @(posedge mclk);
        req <= 1'b0;
        quiet = 0;
        repeat (3)
        begin
            @(negedge mclk);
            if (done !== 1'b0)
                quiet++;
        end
        check("nop_done", 16'(quiet), 16'h0000);
        check("status", {8'h00, status}, {8'h00, st});
        sw_rd(`STATUS_ADDR, st);
        sw_rd(6'h09, rf[9]);
        // Unmapped place must read zero after a write
        sw_wr(6'h25, 8'h5a);
        sw_rd(6'h25, 8'h00);
        wrap_up();
    end
endmodule
